//--- verilog/gpt_pkg.sv
// Shared constants and types for the general-purpose timer block.
`default_nettype none
package gpt_pkg;
    // Register byte offsets.
    localparam logic [11:0] OFF_CFG = 12'h000;
    localparam logic [11:0] OFF_MODE = 12'h004;
    localparam logic [11:0] OFF_CTL = 12'h00c;
    localparam logic [11:0] OFF_IMR = 12'h018;
    localparam logic [11:0] OFF_RIS = 12'h01c;
    localparam logic [11:0] OFF_MIS = 12'h020;
    localparam logic [11:0] OFF_ICR = 12'h024;
    localparam logic [11:0] OFF_ILR = 12'h028;
    localparam logic [11:0] OFF_MATCH = 12'h030;
    localparam logic [11:0] OFF_PRE = 12'h038;
    localparam logic [11:0] OFF_CNT = 12'h048;
    // Configuration values.
    localparam logic [2:0] CFG_32 = 3'h0;
    localparam logic [2:0] CFG_RTC = 3'h1;
    localparam logic [2:0] CFG_16 = 3'h4;
    // Mode register fields.
    localparam int MODE_MR_LSB = 0;
    localparam int MODE_CMR_BIT = 2;
    localparam int MODE_AMS_BIT = 3;
    localparam logic [1:0] MR_ONESHOT = 2'h1;
    localparam logic [1:0] MR_PERIODIC = 2'h2;
    localparam logic [1:0] MR_CAPTURE = 2'h3;
    // Control register fields.
    localparam int CTL_RUN_BIT = 0;
    localparam int CTL_EVT_LSB = 2;
    localparam int CTL_STALL_BIT = 4;
    localparam int CTL_INV_BIT = 6;
    localparam logic [6:0] CTL_MASK = 7'h5d;
    localparam logic [1:0] EVT_RISE = 2'h0;
    localparam logic [1:0] EVT_FALL = 2'h1;
    localparam logic [1:0] EVT_BOTH = 2'h3;
    // Status bit positions, shared by mask, raw, masked and clear.
    localparam int ST_TIMEOUT = 0;
    localparam int ST_MATCH = 1;
    localparam int ST_CAPTURE = 2;
    localparam int ST_CLOCK = 3;
    // Reset and load values.
    localparam logic [31:0] RST_ONES = 32'hffff_ffff;
    localparam logic [31:0] RTC_START = 32'h0000_0001;
    localparam logic [7:0] RST_PRE = 8'h00;
    // Clock-mode input rate and the divider to one second.
    localparam int RTC_HZ = 32768;
    localparam logic [14:0] RTC_DIV_LAST = 15'(RTC_HZ - 1);

    typedef enum logic [2:0] {
        GPT_IDLE,
        GPT_ONESHOT,
        GPT_PERIODIC,
        GPT_RTC,
        GPT_ECOUNT,
        GPT_ETIME,
        GPT_PWM
    } gpt_mode_t;
endpackage
`default_nettype wire

//--- verilog/gpt_edge_sync.sv
// Pin synchroniser with rising and falling edge detection.
`default_nettype none
module gpt_edge_sync (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pin level and detected edges
    input wire logic pin,
    output logic rise,
    output logic fall
);
    logic meta;
    logic sync;
    logic prev;

    // Only sync and prev are looked at, so meta never feeds logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= pin;
            sync <= meta;
            prev <= sync;
        end
    end

    assign rise = sync & ~prev;
    assign fall = ~sync & prev;
endmodule
`default_nettype wire

//--- verilog/gpt_timer.sv
// General-purpose timer with capture, PWM and APB register access.
//
// Contract
// R01 - Edge source holds level two clocks
// R02 - Prescaler bypassed in edge and PWM modes
// R03 - Rising, falling or both edges selectable
// R04 - Capture select: zero count, one time
// R05 - Edge count decrements once per edge
// R06 - Count match sets raw match flag
// R07 - On match reload, stop, ignore edges
// R08 - Edge time counts down from load value
// R09 - Edge captures count and sets flag
// R10 - Edge time keeps running, reloads at zero
// R11 - Captured value held until next edge
// R12 - Software selects PWM by mode bits
// R13 - PWM counts down, reloads after zero
// R14 - PWM sets no status flags
// R15 - PWM high at load, low at match
// R16 - PWM output changes only on clock
// R17 - Software stops timer before reconfiguring
// R18 - Software sequence for full-width timer
// R19 - Clear bit clears timeout raw and masked
// R20 - One-shot stops, periodic keeps counting
// R21 - Software sequence for clock mode
// R22 - Clock match flag, counts on, clearable; the code restarts the count from zero at match
// R23 - Software sequence for half-width timer
// R24 - Load write while running applies next cycle; running edge count takes it only at match reload, clock mode never
// R25 - Pin synchronised and edge detected
// R26 - Reset clears state, load and count ones
`default_nettype none
module gpt_timer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Capture and compare pin
    input wire logic ccp_in,
    output logic ccp_out,
    output logic ccp_oe
);
    logic [2:0] cfg;
    logic [3:0] mode_reg;
    logic [6:0] ctl;
    logic [3:0] imr;
    logic [3:0] ris;
    logic [31:0] ilr;
    logic [31:0] match;
    logic [7:0] prescale;
    logic [31:0] cnt;
    logic [31:0] cap;
    logic [7:0] pre_cnt;
    logic [14:0] div_cnt;
    logic ld_pend;
    logic pwm_lvl;

    logic [31:0] next_cnt;
    logic [31:0] next_cap;
    logic [7:0] next_pre;
    logic [14:0] next_div;
    logic [3:0] next_ev;
    logic next_stop;
    logic next_pwm;
    logic [31:0] rd_data;
    logic rd_ok;

    gpt_pkg::gpt_mode_t mode;
    logic half;
    logic run;
    logic [31:0] ilr_eff;
    logic [31:0] match_eff;
    logic rise;
    logic fall;
    logic edge_hit;
    logic wr;
    logic wr_cfg;
    logic wr_ilr;

    // Half-width modes only see the low sixteen bits of a value.
    function automatic logic [31:0] lim(input logic [31:0] v,
                                        input logic h);
        lim = h ? {16'h0000, v[15:0]} : v;
    endfunction

    function automatic gpt_pkg::gpt_mode_t decode(input logic [2:0] c,
                                                  input logic [3:0] m);
        logic [1:0] mr;
        mr = m[gpt_pkg::MODE_MR_LSB +: 2];
        decode = gpt_pkg::GPT_IDLE;
        if (c == gpt_pkg::CFG_RTC) begin
            decode = gpt_pkg::GPT_RTC;
        end else if (c == gpt_pkg::CFG_32 || c == gpt_pkg::CFG_16) begin
            if (c == gpt_pkg::CFG_16 && m[gpt_pkg::MODE_AMS_BIT] &&
                mr == gpt_pkg::MR_PERIODIC) begin
                decode = gpt_pkg::GPT_PWM;
            // R04 capture select
            end else if (c == gpt_pkg::CFG_16 &&
                         mr == gpt_pkg::MR_CAPTURE) begin
                decode = m[gpt_pkg::MODE_CMR_BIT] ? gpt_pkg::GPT_ETIME
                                                  : gpt_pkg::GPT_ECOUNT;
            end else if (mr == gpt_pkg::MR_ONESHOT) begin
                decode = gpt_pkg::GPT_ONESHOT;
            end else if (mr == gpt_pkg::MR_PERIODIC) begin
                decode = gpt_pkg::GPT_PERIODIC;
            end
        end
    endfunction

    assign mode = decode(cfg, mode_reg);
    assign half = (cfg == gpt_pkg::CFG_16);
    assign run = ctl[gpt_pkg::CTL_RUN_BIT];
    assign ilr_eff = lim(ilr, half);
    assign match_eff = lim(match, half);
    assign wr = psel & penable & pwrite & pready;
    assign wr_cfg = wr && paddr == gpt_pkg::OFF_CFG;
    assign wr_ilr = wr && paddr == gpt_pkg::OFF_ILR;

    // R25 pin synchroniser
    gpt_edge_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(ccp_in),
        .rise(rise),
        .fall(fall)
    );

    // R03 edge select
    always_comb begin
        case (ctl[gpt_pkg::CTL_EVT_LSB +: 2])
            gpt_pkg::EVT_RISE: edge_hit = rise;
            gpt_pkg::EVT_FALL: edge_hit = fall;
            gpt_pkg::EVT_BOTH: edge_hit = rise | fall;
            default: edge_hit = 1'b0;
        endcase
    end

    always_comb begin
        next_cnt = cnt;
        next_cap = cap;
        next_pre = pre_cnt;
        next_div = div_cnt;
        next_ev = 4'h0;
        next_stop = 1'b0;
        if (ld_pend) begin
            // R24 deferred reload
            next_cnt = ilr_eff;
            next_pre = prescale;
        end else if (run) begin
            case (mode)
                gpt_pkg::GPT_ONESHOT, gpt_pkg::GPT_PERIODIC: begin
                    if (half && pre_cnt != 8'h00) begin
                        next_pre = pre_cnt - 8'h01;
                    end else begin
                        next_pre = prescale;
                        if (cnt == 32'h0) begin
                            next_cnt = ilr_eff;
                            next_ev[gpt_pkg::ST_TIMEOUT] = 1'b1;
                            // R20 one-shot stop
                            next_stop = (mode == gpt_pkg::GPT_ONESHOT);
                        end else begin
                            next_cnt = cnt - 32'h1;
                        end
                    end
                end
                gpt_pkg::GPT_RTC: begin
                    if (rise) begin
                        if (div_cnt == gpt_pkg::RTC_DIV_LAST) begin
                            next_div = 15'h0000;
                            // R22 clock match
                            if (cnt == match) begin
                                next_cnt = 32'h0;
                                next_ev[gpt_pkg::ST_CLOCK] = 1'b1;
                            end else begin
                                next_cnt = cnt + 32'h1;
                            end
                        end else begin
                            next_div = div_cnt + 15'h0001;
                        end
                    end
                end
                gpt_pkg::GPT_ECOUNT: begin
                    // R05 count edges
                    if (edge_hit) begin
                        // R06 match flag
                        if (cnt - 32'h1 == match_eff) begin
                            // R07 reload and stop
                            next_cnt = ilr_eff;
                            next_ev[gpt_pkg::ST_MATCH] = 1'b1;
                            next_stop = 1'b1;
                        end else begin
                            next_cnt = cnt - 32'h1;
                        end
                    end
                end
                gpt_pkg::GPT_ETIME: begin
                    // R08 free-running count
                    // R10 reload at zero
                    next_cnt = (cnt == 32'h0) ? ilr_eff : cnt - 32'h1;
                    // R09 capture on edge
                    if (edge_hit) begin
                        next_cap = cnt;
                        next_ev[gpt_pkg::ST_CAPTURE] = 1'b1;
                    end
                end
                gpt_pkg::GPT_PWM: begin
                    // R13 reload after zero
                    next_cnt = (cnt == 32'h0) ? ilr_eff : cnt - 32'h1;
                end
                default: begin
                end
            endcase
        end
    end

    // R15 set at load, clear at match
    always_comb begin
        next_pwm = pwm_lvl;
        if (mode != gpt_pkg::GPT_PWM || !run) begin
            next_pwm = 1'b0;
        end else if (cnt == ilr_eff) begin
            next_pwm = 1'b1;
        end else if (cnt == match_eff) begin
            next_pwm = 1'b0;
        end
    end

    // R26 reset to ones
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= gpt_pkg::RST_ONES;
        end else if (wr_cfg && pwdata[2:0] == gpt_pkg::CFG_RTC) begin
            cnt <= gpt_pkg::RTC_START;
        end else begin
            cnt <= next_cnt;
        end
    end

    // R02 prescaler only in timed modes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_cnt <= gpt_pkg::RST_PRE;
            div_cnt <= 15'h0000;
        end else begin
            pre_cnt <= next_pre;
            div_cnt <= next_div;
        end
    end

    // R11 capture held
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cap <= gpt_pkg::RST_ONES;
        end else begin
            cap <= next_cap;
        end
    end

    // R24 load write while running
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ld_pend <= 1'b0;
        end else begin
            ld_pend <= wr_ilr && mode != gpt_pkg::GPT_RTC &&
                       !(run && mode == gpt_pkg::GPT_ECOUNT);
        end
    end

    // Software writes win over the hardware stop; both never meet in
    // practice since reconfiguration is done with the timer stopped.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl <= 7'h00;
        end else if (wr && paddr == gpt_pkg::OFF_CTL) begin
            ctl <= pwdata[6:0] & gpt_pkg::CTL_MASK;
        end else if (next_stop) begin
            ctl[gpt_pkg::CTL_RUN_BIT] <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= 3'h0;
            mode_reg <= 4'h0;
            imr <= 4'h0;
            ilr <= gpt_pkg::RST_ONES;
            match <= gpt_pkg::RST_ONES;
            prescale <= gpt_pkg::RST_PRE;
        end else if (wr) begin
            case (paddr)
                gpt_pkg::OFF_CFG: cfg <= pwdata[2:0];
                gpt_pkg::OFF_MODE: mode_reg <= pwdata[3:0];
                gpt_pkg::OFF_IMR: imr <= pwdata[3:0];
                gpt_pkg::OFF_ILR: ilr <= pwdata;
                gpt_pkg::OFF_MATCH: match <= pwdata;
                gpt_pkg::OFF_PRE: prescale <= pwdata[7:0];
                default: begin
                end
            endcase
        end
    end

    // R14 no flags in PWM
    // R19 write one to clear
    // A new event in the clearing cycle survives the clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ris <= 4'h0;
        end else if (wr && paddr == gpt_pkg::OFF_ICR) begin
            ris <= (ris & ~pwdata[3:0]) | next_ev;
        end else begin
            ris <= ris | next_ev;
        end
    end

    // R16 registered output
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwm_lvl <= 1'b0;
            ccp_out <= 1'b0;
            ccp_oe <= 1'b0;
        end else begin
            pwm_lvl <= next_pwm;
            ccp_out <= next_pwm ^ ctl[gpt_pkg::CTL_INV_BIT];
            ccp_oe <= (mode == gpt_pkg::GPT_PWM);
        end
    end

    always_comb begin
        rd_ok = 1'b1;
        rd_data = 32'h0;
        case (paddr)
            gpt_pkg::OFF_CFG: rd_data = {29'h0, cfg};
            gpt_pkg::OFF_MODE: rd_data = {28'h0, mode_reg};
            gpt_pkg::OFF_CTL: rd_data = {25'h0, ctl};
            gpt_pkg::OFF_IMR: rd_data = {28'h0, imr};
            gpt_pkg::OFF_RIS: rd_data = {28'h0, ris};
            gpt_pkg::OFF_MIS: rd_data = {28'h0, ris & imr};
            gpt_pkg::OFF_ICR: rd_data = 32'h0;
            gpt_pkg::OFF_ILR: rd_data = ilr_eff;
            gpt_pkg::OFF_MATCH: rd_data = match_eff;
            gpt_pkg::OFF_PRE: rd_data = {24'h0, prescale};
            gpt_pkg::OFF_CNT:
                rd_data = (mode == gpt_pkg::GPT_ETIME) ? cap : cnt;
            default: rd_ok = 1'b0;
        endcase
    end

    // Answer one cycle after setup so every access takes two cycles.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            prdata <= (psel & ~penable & ~pwrite) ? rd_data : 32'h0;
            pslverr <= psel & ~penable & ~rd_ok;
        end
    end
endmodule
`default_nettype wire

//--- tb/gpt_timer_checker.sv
// Concurrent checks on the ports of the general-purpose timer.
`default_nettype none
module gpt_timer_checker (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Capture and compare pin
    input wire logic ccp_in,
    input wire logic ccp_out,
    input wire logic ccp_oe
);
    logic mapped;
    logic commit;
    assign mapped = paddr inside {gpt_pkg::OFF_CFG, gpt_pkg::OFF_MODE,
        gpt_pkg::OFF_CTL, gpt_pkg::OFF_IMR, gpt_pkg::OFF_RIS,
        gpt_pkg::OFF_MIS, gpt_pkg::OFF_ICR, gpt_pkg::OFF_ILR,
        gpt_pkg::OFF_MATCH, gpt_pkg::OFF_PRE, gpt_pkg::OFF_CNT};
    assign commit = psel && penable && pready && pwrite;
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_setup;
        psel && !penable;
    endsequence
    sequence s_read;
        pready && !pwrite;
    endsequence
    // Mode and control writes land on the committing edge and reach the pins one edge later.
    sequence s_quiet;
        !$past(commit) && !$past(commit, 2);
    endsequence
    AST_READY_AFTER_SETUP: assert property (s_setup |=> pready)
        else $error("pready missing after setup");
    AST_READY_ONLY_AFTER_SETUP: assert property (
        pready |-> $past(psel && !penable))
        else $error("pready without setup");
    AST_READY_ONE_CYCLE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_UNMAPPED: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not follow the map");
    AST_DATA_IDLE: assert property (!pready |-> prdata == 32'h0)
        else $error("prdata not zero outside access");
    AST_CLEAR_READS_ZERO: assert property (
        s_read ##0 (paddr == gpt_pkg::OFF_ICR) |-> prdata == 32'h0)
        else $error("clear register read not zero");
    AST_PWM_NO_FLAGS: assert property (
        s_read ##0 (ccp_oe && (paddr == gpt_pkg::OFF_RIS ||
        paddr == gpt_pkg::OFF_MIS)) |-> prdata == 32'h0)
        else $error("status flag seen in pwm mode");
    AST_OE_BY_WRITE: assert property (s_quiet |-> $stable(ccp_oe))
        else $error("ccp_oe moved without a write");
    AST_IDLE_OUT_STEADY: assert property (
        s_quiet ##0 (!ccp_oe && $past(!ccp_oe) && $past(!ccp_oe, 2))
        |-> $stable(ccp_out))
        else $error("ccp_out moved outside pwm");
endmodule
bind gpt_timer gpt_timer_checker chk (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .ccp_in(ccp_in), .ccp_out(ccp_out),
    .ccp_oe(ccp_oe));
`default_nettype wire

//--- tb/gpt_pin_model.sv
// Behavioural model of the external source on the capture pin.
`default_nettype none
module gpt_pin_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Toggle request and pin level
    input wire logic toggle,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [1:0] hold;
    // level held long
    // Requests inside the hold time are dropped, never squeezed in.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin <= 1'b0;
            hold <= 2'h0;
        end else if (toggle && hold == 2'h0) begin
            pin <= ~pin;
            hold <= 2'h3;
        end else if (hold != 2'h0) begin
            hold <= hold - 2'h1;
        end
    end
endmodule
`default_nettype wire

//--- tb/tb_gpt_timer.sv
// Self-checking testbench for the general-purpose timer.
`default_nettype none
module tb_gpt_timer;
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic ccp_in;
    logic ccp_out;
    logic ccp_oe;
    logic toggle = 1'b0;
    logic [64:0] expq[$];
    logic [64:0] e;
    logic [31:0] rv;
    logic [1:0] evts[3] = '{gpt_pkg::EVT_RISE, gpt_pkg::EVT_FALL,
        gpt_pkg::EVT_BOTH};
    int fail_count = 0;
    int checks_done = 0;
    int hi;

    always #4 pclk = ~pclk;

    gpt_timer dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ccp_in(ccp_in), .ccp_out(ccp_out),
        .ccp_oe(ccp_oe));
    gpt_pin_model pin (.pclk(pclk), .presetn(presetn), .toggle(toggle),
        .pin(ccp_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time,
                seen, exp);
        end
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // The request stands until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] d, input logic [31:0] exp,
        input logic [31:0] msk, input logic err);
        expq.push_back({err, msk, exp});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, exp, 32'hffff_ffff, 1'b0);
    endtask

    task automatic edges(input int n);
        repeat (n) begin
            @(posedge pclk);
            toggle <= 1'b1;
            @(posedge pclk);
            toggle <= 1'b0;
            repeat (6) @(posedge pclk);
        end
    endtask

    task automatic count_high(input int n, input int exp);
        hi = 0;
        repeat (n) begin
            @(posedge pclk);
            if (ccp_out === 1'b1) hi++;
        end
        check(32'(hi), 32'(exp));
    endtask

    // Completed transfers are matched against the oldest note.
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && expq.size() > 0) begin
            e = expq.pop_front();
            check(prdata & e[63:32], e[31:0]);
            check({31'h0, pslverr}, {31'h0, e[64]});
        end
    end

    initial begin
        repeat (20000) @(posedge pclk);
        fail_count++;
        summarize();
    end

    initial begin
        rv = $urandom(32'hfe34);
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        rd(gpt_pkg::OFF_CFG, 32'h0);
        rd(gpt_pkg::OFF_MODE, 32'h0);
        rd(gpt_pkg::OFF_CTL, 32'h0);
        rd(gpt_pkg::OFF_IMR, 32'h0);
        rd(gpt_pkg::OFF_RIS, 32'h0);
        rd(gpt_pkg::OFF_PRE, 32'h0);
        rd(gpt_pkg::OFF_ILR, gpt_pkg::RST_ONES);
        rd(gpt_pkg::OFF_MATCH, gpt_pkg::RST_ONES);
        rd(gpt_pkg::OFF_CNT, gpt_pkg::RST_ONES);
        rv = $urandom();
        apb(1'b1, 12'h008, rv, 32'h0, 32'h0, 1'b1);
        apb(1'b0, 12'h008, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
        wr(gpt_pkg::OFF_ILR, rv);
        rd(gpt_pkg::OFF_ILR, rv);
        rv = $urandom();
        wr(gpt_pkg::OFF_PRE, 32'(rv[7:0]));
        rd(gpt_pkg::OFF_PRE, 32'(rv[7:0]));
        wr(gpt_pkg::OFF_RIS, 32'hf);
        rd(gpt_pkg::OFF_RIS, 32'h0);
        wr(gpt_pkg::OFF_CFG, 32'(gpt_pkg::CFG_16));
        wr(gpt_pkg::OFF_MODE, 32'h3);
        wr(gpt_pkg::OFF_IMR, 32'h2);
        wr(gpt_pkg::OFF_ILR, 32'h0a);
        wr(gpt_pkg::OFF_MATCH, 32'h06);
        for (int i = 0; i < 3; i++) begin
            wr(gpt_pkg::OFF_CTL, 32'({evts[i], 2'b01}));
            edges(4);
            rd(gpt_pkg::OFF_CNT, (i == 2) ? 32'h0a : 32'h08);
            rd(gpt_pkg::OFF_RIS, (i == 2) ? 32'h2 : 32'h0);
            edges(4);
            rd(gpt_pkg::OFF_CNT, 32'h0a);
            rd(gpt_pkg::OFF_MIS, 32'h2);
            rd(gpt_pkg::OFF_CTL, 32'({evts[i], 2'b00}));
            wr(gpt_pkg::OFF_ICR, 32'hf);
            rd(gpt_pkg::OFF_RIS, 32'h0);
        end
        wr(gpt_pkg::OFF_MODE, 32'h7);
        wr(gpt_pkg::OFF_ILR, 32'h10);
        wr(gpt_pkg::OFF_IMR, 32'h4);
        wr(gpt_pkg::OFF_CTL, 32'h5);
        repeat (60) @(posedge pclk);
        edges(1);
        rd(gpt_pkg::OFF_RIS, 32'h0);
        edges(1);
        rd(gpt_pkg::OFF_MIS, 32'h4);
        apb(1'b0, gpt_pkg::OFF_CNT, 32'h0, 32'h0, 32'hffff_ffe0, 1'b0);
        wr(gpt_pkg::OFF_CTL, 32'h0);
        wr(gpt_pkg::OFF_ICR, 32'hf);
        wr(gpt_pkg::OFF_CFG, 32'(gpt_pkg::CFG_32));
        wr(gpt_pkg::OFF_MODE, 32'(gpt_pkg::MR_ONESHOT));
        wr(gpt_pkg::OFF_ILR, 32'd40);
        wr(gpt_pkg::OFF_IMR, 32'h1);
        wr(gpt_pkg::OFF_CTL, 32'h1);
        repeat (70) @(posedge pclk);
        rd(gpt_pkg::OFF_MIS, 32'h1);
        rd(gpt_pkg::OFF_CTL, 32'h0);
        wr(gpt_pkg::OFF_ICR, 32'h1);
        rd(gpt_pkg::OFF_RIS, 32'h0);
        rd(gpt_pkg::OFF_MIS, 32'h0);
        wr(gpt_pkg::OFF_MODE, 32'(gpt_pkg::MR_PERIODIC));
        wr(gpt_pkg::OFF_CTL, 32'h1);
        repeat (70) @(posedge pclk);
        rd(gpt_pkg::OFF_CTL, 32'h1);
        wr(gpt_pkg::OFF_ICR, 32'h1);
        repeat (60) @(posedge pclk);
        rd(gpt_pkg::OFF_RIS, 32'h1);
        wr(gpt_pkg::OFF_CTL, 32'h0);
        wr(gpt_pkg::OFF_ICR, 32'hf);
        wr(gpt_pkg::OFF_CFG, 32'(gpt_pkg::CFG_16));
        wr(gpt_pkg::OFF_MODE, 32'(gpt_pkg::MR_ONESHOT));
        wr(gpt_pkg::OFF_PRE, 32'h3);
        wr(gpt_pkg::OFF_ILR, 32'd10);
        wr(gpt_pkg::OFF_CTL, 32'h1);
        repeat (30) @(posedge pclk);
        rd(gpt_pkg::OFF_RIS, 32'h0);
        repeat (30) @(posedge pclk);
        rd(gpt_pkg::OFF_MIS, 32'h1);
        rd(gpt_pkg::OFF_CTL, 32'h0);
        wr(gpt_pkg::OFF_ICR, 32'hf);
        wr(gpt_pkg::OFF_MODE, 32'ha);
        wr(gpt_pkg::OFF_ILR, 32'd20);
        wr(gpt_pkg::OFF_MATCH, 32'd8);
        wr(gpt_pkg::OFF_CTL, 32'h1);
        repeat (25) @(posedge pclk);
        check({31'h0, ccp_oe}, 32'h1);
        count_high(63, 36);
        rd(gpt_pkg::OFF_RIS, 32'h0);
        wr(gpt_pkg::OFF_ILR, 32'd30);
        repeat (35) @(posedge pclk);
        count_high(93, 66);
        wr(gpt_pkg::OFF_CTL, 32'h0);
        wr(gpt_pkg::OFF_ILR, 32'd20);
        wr(gpt_pkg::OFF_CTL, 32'h41);
        repeat (25) @(posedge pclk);
        count_high(63, 27);
        wr(gpt_pkg::OFF_CTL, 32'h0);
        wr(gpt_pkg::OFF_CFG, 32'(gpt_pkg::CFG_RTC));
        rd(gpt_pkg::OFF_CNT, gpt_pkg::RTC_START);
        repeat (4) @(posedge pclk);
        summarize();
    end
endmodule
`default_nettype wire
